// >>> logic/can_mcon_pkg.sv
// constants, types and helpers shared by the message control logic
package can_mcon_pkg;

  // register byte offsets on the register bus
  localparam logic [11:0] IF1_MCON_OFS = 12'h038;
  localparam logic [11:0] IF2_MCON_OFS = 12'h098;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h100;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h104;
  localparam logic [11:0] IRQ_ID_OFS = 12'h108;

  // control word reset value and bits that software may change
  localparam logic [15:0] MCON_RESET = 16'h0000;
  localparam logic [15:0] MCON_WRITABLE = 16'hff8f;

  // control word field positions
  localparam int FRESH_PAYLOAD_BIT = 15;
  localparam int OVERRUN_LOST_BIT = 14;
  localparam int IRQ_PENDING_BIT = 13;
  localparam int FILTER_USE_BIT = 12;
  localparam int TX_IRQ_EN_BIT = 11;
  localparam int RX_IRQ_EN_BIT = 10;
  localparam int AUTOREPLY_BIT = 9;
  localparam int SEND_REQUEST_BIT = 8;
  localparam int LAST_IN_CHAIN_BIT = 7;
  localparam int DLC_LSB = 0;
  localparam int DLC_W = 4;
  localparam logic [3:0] MAX_PAYLOAD = 4'h8;

  // interrupt status layout, one nibble per interface set
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_LOST = 2;
  localparam int EV_REMOTE = 3;
  localparam int EV_PER_IF = 4;
  localparam int IRQ_W = 8;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // interrupt identifier codes
  localparam logic [1:0] ID_NONE = 2'h0;
  localparam logic [1:0] ID_IF1 = 2'h1;
  localparam logic [1:0] ID_IF2 = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_IF1 = 3'b000,
    SEL_IF2 = 3'b001,
    SEL_STATUS = 3'b010,
    SEL_MASK = 3'b011,
    SEL_ID = 3'b100,
    SEL_NONE = 3'b101
  } reg_sel_e;

  // byte count a length code stands for; codes above eight mean eight
  function automatic logic [3:0] payload_bytes(input logic [3:0] dlc);
    payload_bytes = (dlc > MAX_PAYLOAD) ? MAX_PAYLOAD : dlc;
  endfunction

endpackage

// >>> logic/mcon_word.sv
// one message control word with its hardware-driven flag updates
module mcon_word
  import can_mcon_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_strb,
  input wire logic data_store,
  input wire logic sw_data_write,
  input wire logic rx_dir,
  input wire logic tx_ok,
  input wire logic rx_ok,
  input wire logic remote_rx,
  input wire logic [3:0] rx_dlc,
  output logic [15:0] word
);

  logic [15:0] next_word;
  logic [15:0] lane;

  // software write first, hardware events after so that a set wins
  always_comb
  begin
    lane = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & MCON_WRITABLE; // see RULE14
    next_word = word;
    if (wr_en)
    begin
      next_word = (word & ~lane) | (wr_data & lane); // see RULE12
    end
    // a finished send drops the request unless software re-arms it
    if (tx_ok && !(wr_en && wr_strb[1] && wr_data[SEND_REQUEST_BIT]))
    begin
      next_word[SEND_REQUEST_BIT] = 1'b0; // see RULE11
    end
    if (data_store || sw_data_write)
    begin
      next_word[FRESH_PAYLOAD_BIT] = 1'b1; // see RULE2
    end
    // old flag value decides, a same-cycle clear does not hide the loss
    if (data_store && rx_dir && word[FRESH_PAYLOAD_BIT])
    begin
      next_word[OVERRUN_LOST_BIT] = 1'b1; // see RULE3
    end
    if ((tx_ok && word[TX_IRQ_EN_BIT]) || (rx_ok && word[RX_IRQ_EN_BIT]))
    begin
      next_word[IRQ_PENDING_BIT] = 1'b1; // see RULE7 see RULE8
    end
    if (remote_rx && word[AUTOREPLY_BIT])
    begin
      next_word[SEND_REQUEST_BIT] = 1'b1; // see RULE9
    end
    if (data_store)
    begin
      next_word[DLC_LSB +: DLC_W] = rx_dlc; // see RULE13
    end
  end

  // register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      word <= MCON_RESET; // see RULE10
    else
      word <= next_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_STORE_SETS_FRESH: assert property ( // see RULE2
    data_store |=> word[FRESH_PAYLOAD_BIT] ##1 word[FRESH_PAYLOAD_BIT] ||
    $past(wr_en)) else $error("fresh flag not set by store");
  AST_LOST_ON_OVERRUN: assert property ( // see RULE3
    data_store && rx_dir && word[FRESH_PAYLOAD_BIT] |=> word[OVERRUN_LOST_BIT])
    else $error("overrun not flagged");
  AST_TX_PENDS: assert property ( // see RULE7
    tx_ok && word[TX_IRQ_EN_BIT] |=> word[IRQ_PENDING_BIT])
    else $error("tx did not set pending");
  AST_RX_PENDS: assert property ( // see RULE8
    rx_ok && word[RX_IRQ_EN_BIT] |=> word[IRQ_PENDING_BIT])
    else $error("rx did not set pending");
  AST_PEND_KEPT: assert property ( // see RULE7
    (tx_ok || rx_ok) && !word[TX_IRQ_EN_BIT] && !word[RX_IRQ_EN_BIT] &&
    !wr_en |=> $stable(word[IRQ_PENDING_BIT]))
    else $error("pending changed with enables off");
  AST_REMOTE_REQ: assert property ( // see RULE9
    remote_rx && word[AUTOREPLY_BIT] |=> word[SEND_REQUEST_BIT])
    else $error("remote frame did not request send");
  AST_SENT_CLEARS: assert property ( // see RULE11
    tx_ok && !remote_rx && !wr_en |=> !word[SEND_REQUEST_BIT])
    else $error("send request stuck after send");
  AST_DLC_STORED: assert property ( // see RULE13
    data_store |=> word[DLC_LSB +: DLC_W] == $past(rx_dlc))
    else $error("length code not overwritten");
  AST_RESERVED_ZERO: assert property ( // see RULE14
    word[6:4] == 3'b000) else $error("reserved bits set");

endmodule

// >>> logic/can_if_message_control.sv
// message control words of both interface sets behind an AXI4-Lite slave
// Functional notes
// RULE1: upper sixteen bits read zero, write zero
// RULE2: fresh flag set on new data, sticky
// RULE3: receive overrun sets lost flag until cleared
// RULE4: pending marks source; identifier picks highest priority
// RULE5: filter-use bit enables acceptance mask
// RULE6: software programs mask before object valid
// RULE7: transmit enable lets sent frame set pending
// RULE8: receive enable lets received frame set pending
// RULE9: autoreply lets remote frame set send request
// RULE10: two words at 0x38, 0x98, reset zero
// RULE11: send request high until send done
// RULE12: last-in-chain bit kept as software writes
// RULE13: length over eight means eight; store overwrites
// RULE14: bits six to four reserved, read zero
//
// The AXI4-Lite slave port was left to the implementer.
module can_if_message_control
  import can_mcon_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [1:0] DATA_STORE,
  input wire logic [1:0] SW_DATA_WRITE,
  input wire logic [1:0] RX_DIR,
  input wire logic [1:0] TX_OK,
  input wire logic [1:0] RX_OK,
  input wire logic [1:0] REMOTE_RX,
  input wire logic [3:0] RX_DLC_IF1,
  input wire logic [3:0] RX_DLC_IF2,
  output logic [1:0] FILTER_USE,
  output logic [1:0] SEND_REQUEST,
  output logic [3:0] PAYLOAD_BYTES_IF1,
  output logic [3:0] PAYLOAD_BYTES_IF2,
  output logic [1:0] IRQ_ID,
  output logic IRQ
);

  // map a byte address onto a register
  function automatic reg_sel_e decode(input logic [11:0] addr);
    decode = SEL_NONE;
    case ({addr[11:2], 2'b00})
      IF1_MCON_OFS: decode = SEL_IF1; // see RULE10
      IF2_MCON_OFS: decode = SEL_IF2; // see RULE10
      IRQ_STATUS_OFS: decode = SEL_STATUS;
      IRQ_MASK_OFS: decode = SEL_MASK;
      IRQ_ID_OFS: decode = SEL_ID;
      default: decode = SEL_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; only the second is used
  logic rst_meta, rst_n;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data held separately, then applied together
  logic aw_full, w_full, next_aw_full, next_w_full;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, wr_fire;
  logic [1:0] next_bresp;
  reg_sel_e wr_sel;

  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = BVALID;
    next_bresp = BRESP;
    wr_sel = decode(aw_addr);
    wr_fire = aw_full && w_full && !BVALID;
    if (AWVALID && AWREADY)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      next_w_full = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (BVALID && BREADY)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      // the identifier is read-only, so writing it is an error too
      next_bresp = (wr_sel == SEL_NONE || wr_sel == SEL_ID) ?
                   RESP_SLVERR : RESP_OKAY;
    end
    // ready only while the holding slot is empty and no answer waits
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      AWREADY <= next_awready;
      WREADY <= next_wready;
      BVALID <= next_bvalid;
      BRESP <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two control words
  logic [15:0] mcon1, mcon2;

  mcon_word u_if1 (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .wr_en(wr_fire && wr_sel == SEL_IF1),
    .wr_data(w_data[15:0]), // see RULE1
    .wr_strb(w_strb[1:0]),
    .data_store(DATA_STORE[0]),
    .sw_data_write(SW_DATA_WRITE[0]),
    .rx_dir(RX_DIR[0]),
    .tx_ok(TX_OK[0]),
    .rx_ok(RX_OK[0]),
    .remote_rx(REMOTE_RX[0]),
    .rx_dlc(RX_DLC_IF1),
    .word(mcon1)
  );

  mcon_word u_if2 (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .wr_en(wr_fire && wr_sel == SEL_IF2),
    .wr_data(w_data[15:0]), // see RULE1
    .wr_strb(w_strb[1:0]),
    .data_store(DATA_STORE[1]),
    .sw_data_write(SW_DATA_WRITE[1]),
    .rx_dir(RX_DIR[1]),
    .tx_ok(TX_OK[1]),
    .rx_ok(RX_OK[1]),
    .remote_rx(REMOTE_RX[1]),
    .rx_dlc(RX_DLC_IF2),
    .word(mcon2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky event status, write-one-to-clear, set wins over clear
  logic [7:0] irq_status, irq_mask, next_irq_status, next_irq_mask, events;
  logic next_irq;
  logic [1:0] next_irq_id, next_filter_use, next_send_request;
  logic [3:0] next_bytes1, next_bytes2;

  always_comb
  begin
    events = {REMOTE_RX[1], DATA_STORE[1] & RX_DIR[1] & mcon2[15],
              TX_OK[1], RX_OK[1],
              REMOTE_RX[0], DATA_STORE[0] & RX_DIR[0] & mcon1[15],
              TX_OK[0], RX_OK[0]};
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr_fire && wr_sel == SEL_STATUS && w_strb[0])
      next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
    if (wr_fire && wr_sel == SEL_MASK && w_strb[0])
      next_irq_mask = w_data[IRQ_W-1:0];
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
    // interface set one has the higher priority
    if (mcon1[IRQ_PENDING_BIT])
      next_irq_id = ID_IF1; // see RULE4
    else if (mcon2[IRQ_PENDING_BIT])
      next_irq_id = ID_IF2; // see RULE4
    else
      next_irq_id = ID_NONE;
    next_filter_use = {mcon2[FILTER_USE_BIT], mcon1[FILTER_USE_BIT]}; // see RULE5
    next_send_request = {mcon2[SEND_REQUEST_BIT], mcon1[SEND_REQUEST_BIT]};
    next_bytes1 = payload_bytes(mcon1[DLC_LSB +: DLC_W]); // see RULE13
    next_bytes2 = payload_bytes(mcon2[DLC_LSB +: DLC_W]); // see RULE13
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      IRQ <= 1'b0;
      IRQ_ID <= ID_NONE;
      FILTER_USE <= 2'h0;
      SEND_REQUEST <= 2'h0;
      PAYLOAD_BYTES_IF1 <= 4'h0;
      PAYLOAD_BYTES_IF2 <= 4'h0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      IRQ <= next_irq;
      IRQ_ID <= next_irq_id;
      FILTER_USE <= next_filter_use;
      SEND_REQUEST <= next_send_request;
      PAYLOAD_BYTES_IF1 <= next_bytes1;
      PAYLOAD_BYTES_IF2 <= next_bytes2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one-cycle answer, data captured at the address handshake
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  reg_sel_e rd_sel;

  always_comb
  begin
    next_rvalid = RVALID;
    next_rdata = RDATA;
    next_rresp = RRESP;
    rd_sel = decode(ARADDR);
    if (RVALID && RREADY)
      next_rvalid = 1'b0;
    if (ARVALID && ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      // upper half is never stored, so it always reads zero
      case (rd_sel)
        SEL_IF1: next_rdata = {16'h0000, mcon1}; // see RULE1
        SEL_IF2: next_rdata = {16'h0000, mcon2}; // see RULE1
        SEL_STATUS: next_rdata = {24'h00_0000, irq_status};
        SEL_MASK: next_rdata = {24'h00_0000, irq_mask};
        SEL_ID: next_rdata = {30'h0000_0000, IRQ_ID};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end
    else
    begin
      ARREADY <= next_arready;
      RVALID <= next_rvalid;
      RDATA <= next_rdata;
      RRESP <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  sequence ar_taken;
    ARVALID && ARREADY;
  endsequence
  sequence write_applied;
    aw_full && w_full && !BVALID;
  endsequence

  AST_READ_UPPER_ZERO: assert property ( // see RULE1
    ar_taken |=> RVALID && RDATA[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  AST_WRITE_ANSWERED: assert property ( // see RULE10
    AWVALID && AWREADY ##[0:8] write_applied |=> BVALID)
    else $error("write got no response");
  AST_PENDING_ID: assert property ( // see RULE4
    mcon1[IRQ_PENDING_BIT] |=> IRQ_ID == ID_IF1)
    else $error("identifier misses set one");
  AST_FILTER_OUT: assert property ( // see RULE5
    ##1 FILTER_USE[0] == $past(mcon1[FILTER_USE_BIT]))
    else $error("filter use output wrong");
  AST_BYTES_CAPPED: assert property ( // see RULE13
    PAYLOAD_BYTES_IF1 <= MAX_PAYLOAD && PAYLOAD_BYTES_IF2 <= MAX_PAYLOAD)
    else $error("payload count above eight");
  AST_IRQ_LEVEL: assert property (IRQ == |(irq_status & irq_mask))
    else $error("interrupt level mismatch");

endmodule

// >>> test/can_handler_model.sv
// far-side message handler model: event pulses into the control words
module can_handler_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [1:0] sel,
  input wire logic [3:0] dlc,
  input wire logic [1:0] dir,
  output logic [1:0] data_store,
  output logic [1:0] sw_data_write,
  output logic [1:0] tx_ok,
  output logic [1:0] rx_ok,
  output logic [1:0] remote_rx,
  output logic [3:0] dlc1,
  output logic [3:0] dlc2,
  output logic [1:0] rx_dir
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] p;
  assign p = go ? sel : 2'b00;
  assign rx_dir = dir;
  // one-cycle pulses, launched on the edge after a command
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_store <= 2'b00;
      sw_data_write <= 2'b00;
      tx_ok <= 2'b00;
      rx_ok <= 2'b00;
      remote_rx <= 2'b00;
      dlc1 <= 4'h0;
      dlc2 <= 4'h0;
    end
    else
    begin
      data_store <= (kind == 3'd0) ? p : 2'b00;
      sw_data_write <= (kind == 3'd1) ? p : 2'b00;
      tx_ok <= (kind == 3'd2) ? p : 2'b00;
      rx_ok <= (kind == 3'd3) ? p : 2'b00;
      remote_rx <= (kind == 3'd4) ? p : 2'b00;
      // toggle outside a store, so a stale code is never taken as valid
      dlc1 <= (p[0] && kind == 3'd0) ? dlc : ~dlc1;
      dlc2 <= (p[1] && kind == 3'd0) ? dlc : ~dlc2;
    end
  end
endmodule

// >>> test/testbench.sv
// register-level testbench of the message control words
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = 0, NRST = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, d;
  logic [3:0] WSTRB = 0, dlc = 0, DLC1, DLC2, PB1, PB2;
  logic [1:0] BRESP, RRESP, r, FU, SR, IRQ_ID, sel = 0, dir = 0;
  logic [1:0] DS, SW, TXO, RXO, RMT, RXD;
  logic IRQ, go = 0;
  logic [2:0] kind = 0;
  int miscompares = 0, n_tests = 0;
  can_if_message_control i_can_if_message_control (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .DATA_STORE(DS), .SW_DATA_WRITE(SW),
    .RX_DIR(RXD), .TX_OK(TXO), .RX_OK(RXO), .REMOTE_RX(RMT),
    .RX_DLC_IF1(DLC1), .RX_DLC_IF2(DLC2), .FILTER_USE(FU),
    .SEND_REQUEST(SR), .PAYLOAD_BYTES_IF1(PB1), .PAYLOAD_BYTES_IF2(PB2),
    .IRQ_ID(IRQ_ID), .IRQ(IRQ));
  can_handler_model i_can_handler_model (.clk(CORE_CLK), .rst_n(NRST),
    .go(go), .kind(kind), .sel(sel), .dlc(dlc), .dir(dir),
    .data_store(DS), .sw_data_write(SW), .tx_ok(TXO), .rx_ok(RXO),
    .remote_rx(RMT), .dlc1(DLC1), .dlc2(DLC2), .rx_dir(RXD));
  initial
  begin
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("tests %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task automatic stuck(input int n);
    if (n >= 60)
    begin
      miscompares++;
      $display("[FAIL] %0t bus handshake timed out", $time);
      end_sim();
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= v;
    WSTRB <= 4'hf;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge CORE_CLK);
      if (AWVALID && AWREADY === 1'b1)
        AWVALID <= 0;
      if (WVALID && WREADY === 1'b1)
        WVALID <= 0;
      if (BVALID === 1'b1)
      begin
        r = BRESP;
        BREADY <= 0;
        break;
      end
    end
    stuck(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge CORE_CLK);
      if (ARVALID && ARREADY === 1'b1)
        ARVALID <= 0;
      if (RVALID === 1'b1)
      begin
        d = RDATA;
        r = RRESP;
        RREADY <= 0;
        break;
      end
    end
    stuck(n);
  endtask
  // one handler event: 0 store, 1 software data, 2 tx, 3 rx, 4 remote
  task automatic ev(input logic [2:0] k, input logic [1:0] s);
    @(posedge CORE_CLK);
    go <= 1;
    kind <= k;
    sel <= s;
    @(posedge CORE_CLK);
    go <= 0;
    repeat (3) @(posedge CORE_CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    NRST <= 1;
    repeat (4) @(posedge CORE_CLK);
    rd(12'h038); chk(d, 32'h0);
    rd(12'h098); chk(d, 32'h0);
    rd(12'h100); chk(d, 32'h0);
    wr(12'h038, 32'h0000ffff); chk(r, 2'h0);
    rd(12'h038); chk(d, 32'h0000ff8f);
    wr(12'h038, 32'h00000080);
    rd(12'h040); chk(d, 32'h0); // unmapped place
    chk(r, 2'h2); // unmapped place answers an error
    wr(12'h108, 32'h1); chk(r, 2'h2); // read-only identifier
    dir <= 2'b11;
    ev(3'd1, 2'b01);
    rd(12'h038); chk(d, 32'h8080);
    dlc <= 4'hc;
    ev(3'd0, 2'b01);
    rd(12'h038); chk(d, 32'hc08c);
    chk(PB1, 4'h8);
    dlc <= 4'h9;
    ev(3'd0, 2'b10);
    rd(12'h098); chk(d, 32'h8009);
    chk(PB2, 4'h8);
    ev(3'd3, 2'b01);
    rd(12'h038); chk(d, 32'hc08c);
    rd(12'h100); chk(d, 32'h05);
    wr(12'h038, 32'h0080);
    rd(12'h038); chk(d, 32'h0080);
    wr(12'h098, 32'h0480);
    ev(3'd3, 2'b10);
    rd(12'h098); chk(d, 32'h2480);
    chk(IRQ_ID, 2'h2);
    wr(12'h038, 32'h0980);
    // the output is launched at the edge that closes the write
    @(posedge CORE_CLK);
    chk(SR[0], 1'b1);
    ev(3'd2, 2'b01);
    rd(12'h038); chk(d, 32'h2880);
    chk({SR[0], IRQ_ID}, 3'h1);
    wr(12'h098, 32'h0180);
    ev(3'd2, 2'b10);
    rd(12'h098); chk(d, 32'h0080);
    wr(12'h098, 32'h0280);
    ev(3'd4, 2'b10);
    rd(12'h098); chk(d, 32'h0380);
    chk(SR[1], 1'b1);
    wr(12'h038, 32'h0080);
    ev(3'd4, 2'b01);
    rd(12'h038); chk(d, 32'h0080);
    // filter use set only once the object is set up
    wr(12'h038, 32'h1080);
    repeat (2) @(posedge CORE_CLK);
    chk(FU, 2'b01);
    wr(12'h100, 32'hff);
    rd(12'h100); chk(d, 32'h0);
    wr(12'h104, 32'h01);
    rd(12'h104); chk(d, 32'h01);
    ev(3'd3, 2'b01);
    chk(IRQ, 1'b1);
    wr(12'h100, 32'h01);
    ev(3'd3, 2'b10);
    rd(12'h100); chk(d, 32'h10);
    chk(IRQ, 1'b0); // masked event raises nothing
    // transmit-direction object: a second store loses nothing
    dir <= 2'b01;
    dlc <= 4'h5;
    ev(3'd0, 2'b10);
    ev(3'd0, 2'b10);
    rd(12'h098); chk(d, 32'h8385);
    chk(PB2, 4'h5);
    rd(12'h100); chk(d, 32'h10);
    end_sim();
  end
endmodule
